// ---- rtl/sub_pkg.sv ----
// package: opcodes, field layouts, phase states and carriers for the subtract datapath
package sub_pkg;
    // opcode prefixes of the three subtract operations
    localparam logic [7:0] SUB_LIT_OPC = 8'h08;        // literal_minus_acc_op, 16-bit word bits 15:8
    localparam logic [5:0] SUB_FILE_OPC = 6'h17;       // file_minus_acc_op, bits 15:10
    localparam logic [5:0] SUB_FILEB_OPC = 6'h16;      // file_minus_acc_borrow_op, bits 15:10
    // instruction word field positions
    localparam int SUB_D_BIT = 9;                      // destination select
    localparam int SUB_A_BIT = 8;                      // bank access select
    // reset values and the access bank page
    localparam logic [7:0] SUB_ACC_RST = 8'h00;
    localparam logic [3:0] SUB_BANK_RST = 4'h0;
    localparam logic [3:0] SUB_ACCESS_BANK = 4'h0;     // access bank page
    localparam logic [4:0] SUB_FLAGS_RST = 5'h00;

    // instruction phases, one quarter each
    typedef enum logic [1:0] {SUB_Q1, SUB_Q2, SUB_Q3, SUB_Q4} sub_phase_t;
    // operation kinds after decode
    typedef enum logic [1:0] {SUB_NONE, SUB_LIT, SUB_FILE, SUB_FILEB} sub_op_t;

    // status flags carrier
    typedef struct packed {
        logic neg;
        logic ovf;        // overflow_flag
        logic dcarry;     // digit_carry_flag
        logic zero;
        logic carry;
    } sub_flags_t;

    // file register access carrier
    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] addr;
        logic [7:0] data;
        logic       req;
    } sub_file_t;

    // whole module state
    typedef struct packed {
        sub_phase_t phase;
        sub_op_t    op;
        logic       dest_file;
        logic [7:0] lit;
        logic [7:0] opnd;
        logic [7:0] result;
        sub_flags_t calc;
        sub_flags_t flags;
        logic [7:0] acc;
        sub_file_t  rd;
        sub_file_t  wr;
        logic       done;
    } sub_state_t;
endpackage : sub_pkg

// ---- rtl/sub_datapath.sv ----
// subtract datapath: operand select, borrow arithmetic, flags and destination over a 4-phase cycle
// Behaviour
// - literal minus accumulator goes to accumulator
// - file minus accumulator, minus inverted carry in the borrow form
// - destination bit 0 accumulator, 1 file
// - access bit 0 access bank, else bank select
// - one word, four phases: decode read process write
`timescale 1ns/100ps
module sub_datapath (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // instruction word, sampled in the decode phase
    input wire logic [15:0] instr,
    // bank select register from the core
    input wire logic [3:0] bank_select_register,
    // file register read data, valid in the process phase
    input wire logic [7:0] file_rdata,
    // file register read request
    output logic file_rd_req,
    output logic [3:0] file_rd_bank,
    output logic [7:0] file_rd_addr,
    // file register write request, one pulse in the clock after the write phase, as the phase returns to decode
    output logic file_wr_req,
    output logic [3:0] file_wr_bank,
    output logic [7:0] file_wr_addr,
    output logic [7:0] file_wr_data,
    // architectural state
    output logic [7:0] acc,
    output sub_pkg::sub_flags_t flags,
    output sub_pkg::sub_phase_t phase,
    output logic done
);
    sub_pkg::sub_state_t s_q; // registered state
    sub_pkg::sub_state_t s_d; // next state

    // subtract with borrow-in; carry out is the not-borrow
    // a carry-in of one gives the plain subtract, the borrow form passes the old carry
    // the low-nibble sum gives the digit carry with the same not-borrow sense
    function automatic sub_pkg::sub_flags_t sub_flags(input logic [7:0] a, input logic [7:0] b,
                                                      input logic cin, output logic [7:0] r);
        logic [8:0] full;
        logic [4:0] low;
        sub_pkg::sub_flags_t f;
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        r = full[7:0];
        f.carry = full[8];
        f.dcarry = low[4];
        f.zero = (full[7:0] == 8'h00);
        f.neg = full[7];
        f.ovf = (a[7] != b[7]) && (full[7] != a[7]);
        return f;
    endfunction : sub_flags

    // next-state logic: one phase advance per clock
    always_comb begin
        logic [7:0] r;
        logic cin;
        sub_pkg::sub_flags_t f;
        r = 8'h00;
        s_d = s_q;
        s_d.rd.req = 1'b0;
        s_d.wr.req = 1'b0;
        s_d.done = 1'b0;
        cin = 1'b1;
        f = sub_pkg::SUB_FLAGS_RST;
        unique case (s_q.phase)
            sub_pkg::SUB_Q1: begin // decode
                s_d.phase = sub_pkg::SUB_Q2;
                s_d.lit = instr[7:0];
                s_d.dest_file = instr[sub_pkg::SUB_D_BIT];
                s_d.rd.addr = instr[7:0];
                // access bit low overrides bank select
                s_d.rd.bank = instr[sub_pkg::SUB_A_BIT] ? bank_select_register
                                                        : sub_pkg::SUB_ACCESS_BANK;
                // every word is decoded; a foreign word still runs its four phases
                if (instr[15:8] == sub_pkg::SUB_LIT_OPC) begin
                    s_d.op = sub_pkg::SUB_LIT;
                end else if (instr[15:10] == sub_pkg::SUB_FILE_OPC) begin
                    s_d.op = sub_pkg::SUB_FILE;
                end else if (instr[15:10] == sub_pkg::SUB_FILEB_OPC) begin
                    s_d.op = sub_pkg::SUB_FILEB;
                end else begin
                    s_d.op = sub_pkg::SUB_NONE; // other instructions are not ours
                end
            end
            // bank and address were latched at decode, so the read request is registered now and goes out in the process phase
            sub_pkg::SUB_Q2: begin // operand read
                s_d.phase = sub_pkg::SUB_Q3;
                s_d.rd.req = (s_q.op == sub_pkg::SUB_FILE) || (s_q.op == sub_pkg::SUB_FILEB);
            end
            sub_pkg::SUB_Q3: begin // process: data from file read arrives now
                s_d.phase = sub_pkg::SUB_Q4;
                s_d.opnd = (s_q.op == sub_pkg::SUB_LIT) ? s_q.lit : file_rdata;
                // carry acts as active-low borrow only in the borrow form
                if (s_q.op == sub_pkg::SUB_FILEB) begin
                    cin = s_q.flags.carry;
                end
                f = sub_flags(s_d.opnd, s_q.acc, cin, r);
                s_d.result = r;
                s_d.calc = f;
            end
            sub_pkg::SUB_Q4: begin // write to destination
                s_d.phase = sub_pkg::SUB_Q1;
                // a foreign word ends here with nothing committed
                if (s_q.op != sub_pkg::SUB_NONE) begin
                    s_d.flags = s_q.calc;
                    s_d.done = 1'b1;
                    if (s_q.op == sub_pkg::SUB_LIT || !s_q.dest_file) begin
                        s_d.acc = s_q.result;
                    end else begin
                        s_d.wr.req = 1'b1;
                        s_d.wr.bank = s_q.rd.bank;
                        s_d.wr.addr = s_q.rd.addr;
                        s_d.wr.data = s_q.result;
                    end
                end
            end
        endcase
    end

    // state register, synchronous reset
    // reset parks the phase at decode, so the first word after release is taken
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.phase <= sub_pkg::SUB_Q1;
            s_q.acc <= sub_pkg::SUB_ACC_RST;
            s_q.flags <= sub_pkg::SUB_FLAGS_RST;
            s_q.rd.bank <= sub_pkg::SUB_BANK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    // no logic after the register, so every output is a clean flop output
    assign file_rd_req = s_q.rd.req;
    assign file_rd_bank = s_q.rd.bank;
    assign file_rd_addr = s_q.rd.addr;
    assign file_wr_req = s_q.wr.req;
    assign file_wr_bank = s_q.wr.bank;
    assign file_wr_addr = s_q.wr.addr;
    assign file_wr_data = s_q.wr.data;
    assign acc = s_q.acc;
    assign flags = s_q.flags;
    assign phase = s_q.phase;
    assign done = s_q.done;

    // checks: phase sequencing, one instruction per four clocks
    // the wrap from the write phase back to decode closes every instruction
    phase_cycle_a: assert property (@(posedge clk) disable iff (!resetn)
        phase == sub_pkg::SUB_Q4 |=> phase == sub_pkg::SUB_Q1)
        else $error("phase did not wrap");
    // commits can never come faster than one per instruction cycle
    done_spacing_a: assert property (@(posedge clk) disable iff (!resetn)
        done |=> !done [*3])
        else $error("done closer than four clocks");
    // the operand read is only requested in the process quarter
    read_phase_a: assert property (@(posedge clk) disable iff (!resetn)
        file_rd_req |-> phase == sub_pkg::SUB_Q3)
        else $error("file read outside the process phase");
    // bank choice: the access bank when the access bit is clear
    bank_access_a: assert property (@(posedge clk) disable iff (!resetn)
        phase == sub_pkg::SUB_Q1 && !instr[sub_pkg::SUB_A_BIT]
        |=> file_rd_bank == sub_pkg::SUB_ACCESS_BANK)
        else $error("access bank not used");
    // bank choice: the bank select register when the access bit is set
    bank_select_a: assert property (@(posedge clk) disable iff (!resetn)
        phase == sub_pkg::SUB_Q1 && instr[sub_pkg::SUB_A_BIT]
        |=> file_rd_bank == $past(bank_select_register))
        else $error("bank select not used");
    // literal form: acc four clocks on is the literal minus the old acc
    lit_result_a: assert property (@(posedge clk) disable iff (!resetn)
        phase == sub_pkg::SUB_Q1 && instr[15:8] == sub_pkg::SUB_LIT_OPC
        |=> ##3 acc == 8'(8'($past(instr, 4)) - $past(acc, 4)))
        else $error("literal subtract wrong");
    // literal form never writes the file, whatever the word's low opcode bits hold
    lit_no_write_a: assert property (@(posedge clk) disable iff (!resetn)
        done && s_q.op == sub_pkg::SUB_LIT |-> !file_wr_req)
        else $error("literal subtract wrote a file register");
    // file destination: a write leaves the accumulator alone
    wr_dest_a: assert property (@(posedge clk) disable iff (!resetn)
        file_wr_req |-> $past(s_q.dest_file) && $stable(acc))
        else $error("file write with accumulator destination");
    // file destination: every file-form commit with d set sends the result out
    file_dest_a: assert property (@(posedge clk) disable iff (!resetn)
        done && s_q.op != sub_pkg::SUB_LIT && s_q.dest_file
        |-> file_wr_req && file_wr_data == s_q.result)
        else $error("file destination not written");
    // accumulator destination: result lands in acc, no write pulse
    acc_dest_a: assert property (@(posedge clk) disable iff (!resetn)
        done && s_q.op != sub_pkg::SUB_LIT && !s_q.dest_file
        |-> acc == s_q.result && !file_wr_req)
        else $error("accumulator destination not honoured");
    // borrow form: the carry from before the commit acts as a not-borrow
    borrow_a: assert property (@(posedge clk) disable iff (!resetn)
        phase == sub_pkg::SUB_Q3 && s_q.op == sub_pkg::SUB_FILEB
        |=> s_q.result == 8'($past(file_rdata) - acc - {7'h00, ~flags.carry}))
        else $error("borrow subtract wrong");
    // zero and negative follow the committed result
    flag_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        done |-> flags.zero == (s_q.result == 8'h00) && flags.neg == s_q.result[7])
        else $error("flags not updated");
    // carry is clear exactly when the plain file subtract borrows
    carry_a: assert property (@(posedge clk) disable iff (!resetn)
        phase == sub_pkg::SUB_Q3 && s_q.op == sub_pkg::SUB_FILE
        |=> s_q.calc.carry == ($past(file_rdata) >= acc))
        else $error("carry not the not-borrow");
    // a word that is not a subtract leaves acc and flags alone
    refused_word_a: assert property (@(posedge clk) disable iff (!resetn)
        phase == sub_pkg::SUB_Q4 && s_q.op == sub_pkg::SUB_NONE
        |=> $stable(acc) && $stable(flags) && !done && !file_wr_req)
        else $error("non-subtract word changed state");
    // main scenarios reached
    lit_cov: cover property (@(posedge clk) done && s_q.op == sub_pkg::SUB_LIT);
    fileb_cov: cover property (@(posedge clk) done && s_q.op == sub_pkg::SUB_FILEB);
    wr_cov: cover property (@(posedge clk) file_wr_req);
    acc_dest_cov: cover property (@(posedge clk)
        done && s_q.op == sub_pkg::SUB_FILE && !s_q.dest_file);
    borrow_in_cov: cover property (@(posedge clk)
        phase == sub_pkg::SUB_Q3 && s_q.op == sub_pkg::SUB_FILEB && !flags.carry);
endmodule : sub_datapath

// ---- verif/sub_datapath_bench.sv ----
// self-checking bench for the subtract datapath
`timescale 1ns/100ps
module sub_datapath_bench;
    // one row: instruction word, bank select, file read data, then acc and flags it leaves
    typedef struct packed {logic [15:0] ins; logic [3:0] b; logic [7:0] rd;
        logic [7:0] e_acc; logic [4:0] e_flags;} sub_row_t;
    logic clk, resetn, rd_req, wr_req, done;
    logic [15:0] instr;
    logic [3:0] bank_sel, rd_bank, wr_bank;
    logic [7:0] rdata, rd_addr, wr_addr, wr_data, acc, exp_w;
    sub_pkg::sub_flags_t flags, exp_f;
    sub_pkg::sub_phase_t phase;
    int miscompares = 0, n_compared = 0;
    // ordinary cases; acc and flags worked out by hand, the rest by the model below
    sub_row_t rows [7] = '{'{16'h0802, 4'h0, 8'h00, 8'h02, 5'h05},
        '{16'h0801, 4'h0, 8'h00, 8'hff, 5'h10}, '{16'h5810, 4'h9, 8'h05, 8'h05, 5'h00},
        '{16'h5f20, 4'h3, 8'h05, 8'h05, 5'h07}, '{16'h5b30, 4'h5, 8'h1b, 8'h05, 5'h05},
        '{16'h5c40, 4'h7, 8'h80, 8'h7b, 5'h09}, '{16'h0800, 4'h0, 8'h00, 8'h85, 5'h10}};

    sub_datapath sub_datapath_i (.clk(clk), .resetn(resetn), .instr(instr),
        .bank_select_register(bank_sel), .file_rdata(rdata), .file_rd_req(rd_req),
        .file_rd_bank(rd_bank), .file_rd_addr(rd_addr), .file_wr_req(wr_req),
        .file_wr_bank(wr_bank), .file_wr_addr(wr_addr), .file_wr_data(wr_data),
        .acc(acc), .flags(flags), .phase(phase), .done(done));

    // free-running 8 ns clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // value compare; x or z never passes
    task automatic chk(input logic [15:0] e, input logic [15:0] g, input string n);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one instruction over four phases, started at a falling edge in phase Q1
    task automatic do_op(input logic [15:0] ins, input logic [3:0] b, input logic [7:0] rd);
        logic [8:0] r;
        logic [4:0] lo;
        logic [7:0] x;
        logic cin, lit, fop, dst;
        logic [3:0] bk;
        lit = ins[15:8] == sub_pkg::SUB_LIT_OPC;
        fop = ins[15:10] == sub_pkg::SUB_FILE_OPC || ins[15:10] == sub_pkg::SUB_FILEB_OPC;
        x = lit ? ins[7:0] : rd;
        cin = (ins[15:10] == sub_pkg::SUB_FILEB_OPC) ? exp_f.carry : 1'b1;
        r = {1'b0, x} + {1'b0, ~exp_w} + 9'(cin);
        lo = {1'b0, x[3:0]} + {1'b0, ~exp_w[3:0]} + 5'(cin);
        dst = fop & ins[sub_pkg::SUB_D_BIT];
        bk = ins[sub_pkg::SUB_A_BIT] ? b : sub_pkg::SUB_ACCESS_BANK;
        chk(16'(phase), 16'(sub_pkg::SUB_Q1), "phase");
        instr = ins;
        bank_sel = b;
        rdata = rd;
        repeat (2) @(negedge clk);
        chk(16'(rd_req), 16'(fop), "rd_req");
        if (fop) begin
            chk(16'(rd_bank), 16'(bk), "rd_bank");
            chk(16'(rd_addr), 16'(ins[7:0]), "rd_addr");
        end
        repeat (2) @(negedge clk);
        if (lit | fop) begin
            exp_f = '{neg: r[7], ovf: (x[7] ^ exp_w[7]) & (r[7] ^ x[7]), dcarry: lo[4],
                zero: r[7:0] == 8'h00, carry: r[8]};
            if (!dst) exp_w = r[7:0];
        end
        chk(16'(done), 16'(lit | fop), "done");
        chk(16'(wr_req), 16'(dst), "wr_req");
        if (dst) chk(16'(wr_data), 16'(r[7:0]), "wr_data");
        if (dst) chk(16'({wr_bank, wr_addr}), 16'({bk, ins[7:0]}), "wr_place");
        chk(16'(acc), 16'(exp_w), "acc");
        chk(16'(flags), 16'(exp_f), "flags");
    endtask : do_op

    // verdict, shared by the main sequence and the watchdog
    task automatic wrap_up;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // main sequence, inputs change at falling edges
    initial begin
        {resetn, instr, bank_sel, rdata} = '0;
        exp_w = sub_pkg::SUB_ACC_RST;
        exp_f = sub_pkg::SUB_FLAGS_RST;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        chk(16'({acc, flags}), 16'h0000, "reset_state");
        $display("reset test done");
        foreach (rows[i]) begin
            do_op(rows[i].ins, rows[i].b, rows[i].rd);
            chk(16'(acc), 16'(rows[i].e_acc), "row_acc");
            chk(16'(flags), 16'(rows[i].e_flags), "row_flags");
        end
        $display("table test done");
        // a swap word is not a subtract and must leave acc and flags alone, with no done and no file write
        do_op(16'h3a10, 4'h2, 8'h44);
        $display("refused word test done");
        // reset in mid-instruction, then a borrow that sees the cleared carry
        instr = 16'h08ff;
        repeat (2) @(negedge clk);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        chk(16'(acc), 16'(sub_pkg::SUB_ACC_RST), "mid_reset_acc");
        chk(16'({flags, phase, done, wr_req, rd_req}), 16'h0000, "mid_reset_ctl");
        resetn = 1'b1;
        exp_w = sub_pkg::SUB_ACC_RST;
        exp_f = sub_pkg::SUB_FLAGS_RST;
        do_op(16'h5811, 4'h0, 8'h03);
        $display("mid reset test done");
        wrap_up();
    end

    // watchdog, far beyond the 48 cycles the tests need
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : sub_datapath_bench
